// ### logic/mies_top.sv
// Purpose: management interrupt enables, latched status and either-edge status
// Assumes: pins are asynchronous to clk_sys; register port never stalls
// Notes: read data valid only in the cycle after rd_en
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
module mies_top (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wr_data,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rd_data,
	input  wire logic       gpio_pin_21,
	input  wire logic       gpio_pin_22,
	input  wire logic       gpio_pin_30,
	input  wire logic       gpio_pin_31,
	input  wire logic       gpio_pin_32,
	input  wire logic       gpio_pin_33,
	input  wire logic       gpio_pin_41,
	input  wire logic       gpio_pin_42,
	input  wire logic       gpio_pin_43,
	input  wire logic       gpio_pin_54,
	input  wire logic       gpio_pin_55,
	input  wire logic       gpio_pin_56,
	input  wire logic       gpio_pin_57,
	input  wire logic       gpio_pin_60,
	input  wire logic       gpio_pin_61,
	input  wire logic       fan_tach_in_1,
	input  wire logic       fan_tach_in_2,
	output logic            group_mgmt_irq_n,
	output logic            mgmt_irq_pin_n,
	output logic            serial_irq_req,
	output logic            pm_event_req
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		logic [mies_pkg::NUM_SRC-1:0] sync1;
		logic [mies_pkg::NUM_SRC-1:0] sync2;
		logic [mies_pkg::NUM_SRC-1:0] prev;
		logic [1:0]                   prime;
		logic [7:0]                   enable_4;
		logic [7:0]                   enable_5;
		logic [7:0]                   status_4;
		logic [7:0]                   status_5;
		logic [7:0]                   edge_sts;
		logic [7:0]                   route;
		logic [7:0]                   rd_data;
		logic                         group_n;
		logic                         pin_n;
		logic                         ser_req;
		logic                         pme_req;
	} mies_state_type;

	localparam mies_state_type STATE_RESET = '{
		sync1:    '0,
		sync2:    '0,
		prev:     '0,
		prime:    2'h0,
		enable_4: mies_pkg::RESET_BYTE,
		enable_5: mies_pkg::RESET_BYTE,
		status_4: mies_pkg::RESET_BYTE,
		status_5: mies_pkg::RESET_BYTE,
		edge_sts: mies_pkg::RESET_BYTE,
		route:    mies_pkg::RESET_BYTE,
		rd_data:  8'h00,
		group_n:  1'b1,
		pin_n:    1'b1,
		ser_req:  1'b0,
		pme_req:  1'b0
	};

	mies_state_type                state_reg;
	mies_state_type                state_next;
	logic [mies_pkg::NUM_SRC-1:0] pin_raw;
	logic [mies_pkg::NUM_SRC-1:0] edge_any;
	logic [7:0]                   ev_4;
	logic [7:0]                   ev_5;
	logic [7:0]                   ev_m;
	logic                         pending;
	logic                         wr_edge;
	logic                         wr_st4;
	logic                         wr_st5;

	// clear on write-1, but a same-cycle set wins
	function automatic logic [7:0] mies_w1c(
		input logic [7:0] cur,
		input logic [7:0] set,
		input logic [7:0] clr,
		input logic [7:0] mask
	);
		mies_w1c = ((cur & ~clr) | set) & mask;
	endfunction : mies_w1c

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	always_comb begin
		pin_raw = {
			gpio_pin_60,
			gpio_pin_22,
			gpio_pin_21,
			fan_tach_in_2,
			fan_tach_in_1,
			gpio_pin_57,
			gpio_pin_56,
			gpio_pin_55,
			gpio_pin_54,
			gpio_pin_61,
			gpio_pin_43,
			gpio_pin_42,
			gpio_pin_41,
			gpio_pin_33,
			gpio_pin_32,
			gpio_pin_31,
			gpio_pin_30
		};
		state_next       = state_reg;
		state_next.sync1 = pin_raw;
		state_next.sync2 = state_reg.sync1;
		state_next.prev  = state_reg.sync2;
		if (state_reg.prime != mies_pkg::PRIME_DONE) begin
			state_next.prime = state_reg.prime + 2'h1;
		end
		// either edge, held off until the chain has filled
		edge_any = (state_reg.prime == mies_pkg::PRIME_DONE) ?
			(state_reg.sync2 ^ state_reg.prev) : '0;
		ev_4 = edge_any[7:0];
		ev_5 = {
			edge_any[mies_pkg::SRC_TACH2],
			edge_any[mies_pkg::SRC_TACH1],
			2'b00,
			edge_any[mies_pkg::SRC_GPIO_PIN_54 +: 4]
		};
		ev_m = {
			2'b00,
			edge_any[mies_pkg::SRC_GPIO_PIN_61],
			edge_any[mies_pkg::SRC_GPIO_PIN_60],
			edge_any[mies_pkg::SRC_GPIO_PIN_43],
			edge_any[mies_pkg::SRC_GPIO_PIN_41],
			edge_any[mies_pkg::SRC_GPIO_PIN_22],
			edge_any[mies_pkg::SRC_GPIO_PIN_21]
		};
		wr_edge = wr_en && (addr == mies_pkg::OFS_EDGE_STS);
		wr_st4  = wr_en && (addr == mies_pkg::OFS_STATUS_4);
		wr_st5  = wr_en && (addr == mies_pkg::OFS_STATUS_5);
		// register writes
		if (wr_en && (addr == mies_pkg::OFS_ENABLE_4)) begin
			state_next.enable_4 = wr_data & mies_pkg::MASK_ENABLE_4;
		end
		if (wr_en && (addr == mies_pkg::OFS_ENABLE_5)) begin
			state_next.enable_5 = wr_data & mies_pkg::MASK_ENABLE_5;
		end
		if (wr_en && (addr == mies_pkg::OFS_ROUTE)) begin
			state_next.route = wr_data & mies_pkg::MASK_ROUTE;
		end
		state_next.status_4 = mies_w1c(state_reg.status_4, ev_4,
			wr_st4 ? wr_data : 8'h00, mies_pkg::MASK_ENABLE_4);
		state_next.status_5 = mies_w1c(state_reg.status_5, ev_5,
			wr_st5 ? wr_data : 8'h00, mies_pkg::MASK_ENABLE_5);
		state_next.edge_sts = mies_w1c(state_reg.edge_sts, ev_m,
			wr_edge ? wr_data : 8'h00, mies_pkg::MASK_EDGE_STS);
		// read port, unmapped and reserved addresses answer zero
		state_next.rd_data = 8'h00;
		if (rd_en) begin
			case (addr)
				mies_pkg::OFS_STATUS_4: state_next.rd_data = state_reg.status_4;
				mies_pkg::OFS_STATUS_5: state_next.rd_data = state_reg.status_5;
				mies_pkg::OFS_ROUTE:    state_next.rd_data = state_reg.route;
				mies_pkg::OFS_ENABLE_4: state_next.rd_data = state_reg.enable_4;
				mies_pkg::OFS_ENABLE_5: state_next.rd_data = state_reg.enable_5;
				mies_pkg::OFS_EDGE_STS: state_next.rd_data = state_reg.edge_sts;
				mies_pkg::OFS_RSVD_A:   state_next.rd_data = 8'h00;
				mies_pkg::OFS_RSVD_B:   state_next.rd_data = 8'h00;
				default:                state_next.rd_data = 8'h00;
			endcase
		end
		// group interrupt and its routes
		pending = |((state_reg.status_4 & state_reg.enable_4) |
			(state_reg.status_5 & state_reg.enable_5));
		state_next.group_n = ~pending;
		state_next.pin_n   = ~(pending & state_reg.route[mies_pkg::BIT_ROUTE_PIN]);
		state_next.ser_req = pending & state_reg.route[mies_pkg::BIT_ROUTE_SER];
		state_next.pme_req = pending & state_reg.route[mies_pkg::BIT_ROUTE_PME];
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= STATE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rd_data          = state_reg.rd_data;
	assign group_mgmt_irq_n = state_reg.group_n;
	assign mgmt_irq_pin_n   = state_reg.pin_n;
	assign serial_irq_req   = state_reg.ser_req;
	assign pm_event_req     = state_reg.pme_req;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking mies_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	sequence wr_to_s(logic [7:0] ofs);
		wr_en && (addr == ofs);
	endsequence

	sequence rd_zero_s;
		##1 (rd_data == 8'h00);
	endsequence

	enable4_write_a: assert property (wr_to_s(mies_pkg::OFS_ENABLE_4) |=>
		state_reg.enable_4 == $past(wr_data))
		else $error("enable 4 did not take written value");

	enable5_rsvd_a: assert property (wr_to_s(mies_pkg::OFS_ENABLE_5) |=>
		(state_reg.enable_5 == ($past(wr_data) & 8'hcf)) && (state_reg.enable_5[5:4] == 2'b00))
		else $error("enable 5 reserved bits or value wrong");

	reset_zero_a: assert property (disable iff (1'b0) $past(rst) |->
		(state_reg.enable_4 == 8'h00) && (state_reg.enable_5 == 8'h00) &&
		(state_reg.edge_sts == 8'h00))
		else $error("register not zero after reset");

	rsvd_read_a: assert property (rd_en && ((addr == mies_pkg::OFS_RSVD_A) ||
		(addr == mies_pkg::OFS_RSVD_B)) |-> rd_zero_s)
		else $error("reserved offset read nonzero");

	edge_clear_a: assert property (wr_en && (addr == mies_pkg::OFS_EDGE_STS) &&
		(ev_m == 8'h00) |=> state_reg.edge_sts == ($past(state_reg.edge_sts) & ~$past(wr_data)))
		else $error("edge status write-1 clear wrong");

	edge_low_set_a: assert property (|ev_m[2:0] |=>
		(state_reg.edge_sts[2:0] & $past(ev_m[2:0])) == $past(ev_m[2:0]))
		else $error("edge status bits 2:0 not set");

	edge_high_set_a: assert property (|ev_m[5:3] ##1 !wr_en |=>
		(state_reg.edge_sts[5:3] & $past(ev_m[5:3], 2)) == $past(ev_m[5:3], 2))
		else $error("edge status bits 5:3 not held");

	edge_rsvd_a: assert property (rd_en && (addr == mies_pkg::OFS_EDGE_STS) |=>
		rd_data[7:6] == 2'b00)
		else $error("edge status reserved bits read nonzero");

	status_latch_a: assert property (|ev_4 |=>
		(state_reg.status_4 & $past(ev_4)) == $past(ev_4))
		else $error("status 4 did not latch event");

	route_pin_a: assert property ($rose(pending && state_reg.route[7]) |=>
		!mgmt_irq_pin_n && !group_mgmt_irq_n)
		else $error("routed pin interrupt not asserted");

	group_follow_a: assert property (pending |=> !group_mgmt_irq_n ##0
		(serial_irq_req == $past(state_reg.route[6])))
		else $error("group interrupt or serial route wrong");

	set_wins_a: assert property (wr_en && (addr == mies_pkg::OFS_STATUS_4) &&
		|(ev_4 & wr_data) |=> (state_reg.status_4 & $past(ev_4)) == $past(ev_4))
		else $error("event lost against clear");

	// ----------------------------------------
	// register port reads and writes
	// ----------------------------------------
	sequence rd_from_s(logic [7:0] ofs);
		rd_en && (addr == ofs);
	endsequence

	enable4_read_a: assert property (rd_from_s(mies_pkg::OFS_ENABLE_4) |=>
		rd_data == $past(state_reg.enable_4))
		else $error("enable 4 read back wrong");

	enable5_read_a: assert property (rd_from_s(mies_pkg::OFS_ENABLE_5) |=>
		rd_data == $past(state_reg.enable_5))
		else $error("enable 5 read back wrong");

	edge_read_a: assert property (rd_from_s(mies_pkg::OFS_EDGE_STS) |=>
		rd_data == $past(state_reg.edge_sts))
		else $error("edge status read back wrong");

	status4_read_a: assert property (rd_from_s(mies_pkg::OFS_STATUS_4) |=>
		rd_data == $past(state_reg.status_4))
		else $error("status 4 read back wrong");

	status5_read_a: assert property (rd_from_s(mies_pkg::OFS_STATUS_5) |=>
		rd_data == $past(state_reg.status_5))
		else $error("status 5 read back wrong");

	route_write_a: assert property (wr_to_s(mies_pkg::OFS_ROUTE) |=>
		state_reg.route == ($past(wr_data) & mies_pkg::MASK_ROUTE))
		else $error("route register took wrong value");

	rsvd_write_a: assert property (wr_en && ((addr == mies_pkg::OFS_RSVD_A) ||
		(addr == mies_pkg::OFS_RSVD_B)) |=>
		$stable(state_reg.enable_4) && $stable(state_reg.enable_5) && $stable(state_reg.route))
		else $error("reserved offset write changed a register");

	// ----------------------------------------
	// status and edge latching
	// ----------------------------------------
	edge_keep_a: assert property (wr_en && (addr == mies_pkg::OFS_EDGE_STS) &&
		(wr_data == 8'h00) |=> state_reg.edge_sts == ($past(state_reg.edge_sts) | $past(ev_m)))
		else $error("edge status write of zero changed bits");

	edge_mask_a: assert property (wr_to_s(mies_pkg::OFS_EDGE_STS) |=>
		state_reg.edge_sts[7:6] == 2'b00)
		else $error("edge status reserved bits set");

	status5_latch_a: assert property (|ev_5 |=>
		(state_reg.status_5 & $past(ev_5)) == $past(ev_5))
		else $error("status 5 did not latch event");

	status_clear_a: assert property (wr_en && (addr == mies_pkg::OFS_STATUS_4) &&
		(ev_4 == 8'h00) |=> state_reg.status_4 == ($past(state_reg.status_4) & ~$past(wr_data)))
		else $error("status 4 write-1 clear wrong");

	status5_clear_a: assert property (wr_en && (addr == mies_pkg::OFS_STATUS_5) &&
		(ev_5 == 8'h00) |=> state_reg.status_5 == ($past(state_reg.status_5) & ~$past(wr_data)))
		else $error("status 5 write-1 clear wrong");

	// ----------------------------------------
	// group interrupt and routes
	// ----------------------------------------
	enable_block_a: assert property ((state_reg.enable_4 == 8'h00) &&
		(state_reg.enable_5 == 8'h00) |=> group_mgmt_irq_n)
		else $error("group interrupt with all sources disabled");

	group_clear_a: assert property (!pending |=>
		group_mgmt_irq_n && mgmt_irq_pin_n && !serial_irq_req && !pm_event_req)
		else $error("interrupt outputs active with nothing pending");

	route_pme_a: assert property (pending |=>
		pm_event_req == $past(state_reg.route[mies_pkg::BIT_ROUTE_PME]))
		else $error("pm event route wrong");

	route_pin_level_a: assert property (pending |=>
		mgmt_irq_pin_n == !$past(state_reg.route[mies_pkg::BIT_ROUTE_PIN]))
		else $error("pin route wrong");

endmodule : mies_top

// ### pkg/mies_pkg.sv
// Purpose: constants for the management interrupt enable and edge status block
// Assumes: 8-bit register port, printed offsets used as register addresses
// Notes: pin order of the event vector is fixed by the SRC_ constants below
package mies_pkg;
	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_STATUS_4 = 8'h13;
	localparam logic [7:0] OFS_STATUS_5 = 8'h14;
	localparam logic [7:0] OFS_ROUTE    = 8'h17;
	localparam logic [7:0] OFS_ENABLE_4 = 8'h19;
	localparam logic [7:0] OFS_ENABLE_5 = 8'h1a;
	localparam logic [7:0] OFS_RSVD_A   = 8'h1b;
	localparam logic [7:0] OFS_EDGE_STS = 8'h1c;
	localparam logic [7:0] OFS_RSVD_B   = 8'h1d;
	// ----------------------------------------
	// writable field masks and reset values
	// ----------------------------------------
	localparam logic [7:0] MASK_ENABLE_4 = 8'hff;
	localparam logic [7:0] MASK_ENABLE_5 = 8'hcf;
	localparam logic [7:0] MASK_EDGE_STS = 8'h3f;
	localparam logic [7:0] MASK_ROUTE    = 8'he0;
	localparam int         BIT_ROUTE_PIN = 7;
	localparam int         BIT_ROUTE_SER = 6;
	localparam int         BIT_ROUTE_PME = 5;
	localparam logic [7:0] RESET_BYTE    = 8'h00;
	// ----------------------------------------
	// event source vector layout
	// ----------------------------------------
	localparam int NUM_SRC    = 17;
	localparam int SRC_GPIO_PIN_41   = 4;
	localparam int SRC_GPIO_PIN_43   = 6;
	localparam int SRC_GPIO_PIN_61   = 7;
	localparam int SRC_GPIO_PIN_54   = 8;
	localparam int SRC_TACH1  = 12;
	localparam int SRC_TACH2  = 13;
	localparam int SRC_GPIO_PIN_21   = 14;
	localparam int SRC_GPIO_PIN_22   = 15;
	localparam int SRC_GPIO_PIN_60   = 16;
	// cycles after reset before edge detection is trusted
	localparam logic [1:0] PRIME_DONE = 2'h3;
endpackage : mies_pkg

// ### testbench/mies_pin_model.sv
// Purpose: far-side model of the gpio pins and fan tachometer inputs
// Assumes: bench requests a level flip of chosen pins with one strobe
// Notes: pins move by non-blocking assignment on the rising clock edge
`timescale 1ns/100ps
module mies_pin_model (
	input  wire logic        clk_sys,
	input  wire logic        flip_go,
	input  wire logic [16:0] flip_mask,
	output logic      [16:0] pin_lvl
);
	initial pin_lvl = 17'h0_0000;
	always @(posedge clk_sys) begin
		if (flip_go) begin
			pin_lvl <= pin_lvl ^ flip_mask;
		end
	end
endmodule : mies_pin_model

// ### testbench/tb.sv
// Purpose: self-checking bench for the interrupt enable and edge status block
// Assumes: pin vector order 21,22,30..33,41,42,43,54..57,60,61,tach1,tach2
// Notes: reads sampled on the falling edge of the cycle after the strobe
`timescale 1ns/100ps
module tb;
	logic        clk_sys, rst, wr_en, rd_en, flip_go;
	logic [7:0]  addr, wr_data, rd_data;
	logic [16:0] flip_mask, p;
	logic        grp_n, pin_n, ser, pme;
	int          err_total, checked, cyc;
	// ----------------------------------------
	// pins feeding each edge status bit
	// ----------------------------------------
	localparam logic [16:0] EDGE_PIN [6] = '{17'h0_0001, 17'h0_0002, 17'h0_0040,
		17'h0_0100, 17'h0_2000, 17'h0_4000};
	mies_pin_model pins (.clk_sys(clk_sys), .flip_go(flip_go), .flip_mask(flip_mask),
		.pin_lvl(p));
	mies_top dut (.clk_sys(clk_sys), .rst(rst), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .gpio_pin_21(p[0]),
		.gpio_pin_22(p[1]), .gpio_pin_30(p[2]), .gpio_pin_31(p[3]), .gpio_pin_32(p[4]),
		.gpio_pin_33(p[5]), .gpio_pin_41(p[6]), .gpio_pin_42(p[7]), .gpio_pin_43(p[8]),
		.gpio_pin_54(p[9]), .gpio_pin_55(p[10]), .gpio_pin_56(p[11]),
		.gpio_pin_57(p[12]), .gpio_pin_60(p[13]), .gpio_pin_61(p[14]),
		.fan_tach_in_1(p[15]), .fan_tach_in_2(p[16]), .group_mgmt_irq_n(grp_n),
		.mgmt_irq_pin_n(pin_n), .serial_irq_req(ser), .pm_event_req(pme));
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	task automatic stop_test;
		$display("mismatches %0d of %0d comparisons", err_total, checked);
		if (err_total == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk8
	task automatic chk1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr    <= a;
		wr_data <= d;
		wr_en   <= 1'b1;
		@(posedge clk_sys);
		wr_en   <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk_sys);
		rd_en <= 1'b0;
		@(negedge clk_sys);
		chk8(rd_data, exp);
	endtask : rd
	task automatic flip(input logic [16:0] m);
		@(posedge clk_sys);
		flip_mask <= m;
		flip_go   <= 1'b1;
		@(posedge clk_sys);
		flip_go   <= 1'b0;
		repeat (8) @(negedge clk_sys);
	endtask : flip
	// ----------------------------------------
	// hang guard
	// ----------------------------------------
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc > 5000) begin
			err_total++;
			stop_test();
		end
	end
	initial begin
		logic [7:0] exp;
		err_total = 0; checked = 0; cyc = 0; exp = 8'h00;
		rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; flip_go = 1'b0;
		addr = 8'h00; wr_data = 8'h00; flip_mask = 17'h0_0000;
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (10) @(posedge clk_sys);
		rd(8'h19, 8'h00);
		rd(8'h1a, 8'h00);
		rd(8'h1c, 8'h00);
		chk1(grp_n, 1'b1);
		wr(8'h19, 8'hff);
		rd(8'h19, 8'hff);
		wr(8'h1a, 8'hff);
		rd(8'h1a, 8'hcf);
		wr(8'h19, 8'h00);
		wr(8'h1a, 8'h00);
		wr(8'h1b, 8'hff);
		wr(8'h1d, 8'hff);
		rd(8'h1b, 8'h00);
		rd(8'h1d, 8'h00);
		for (int i = 0; i < 6; i++) begin
			flip(EDGE_PIN[i]);
			exp = exp | (8'h01 << i);
			rd(8'h1c, exp);
		end
		flip(17'h0_6143);
		chk1(grp_n, 1'b1);
		wr(8'h1c, 8'h01);
		rd(8'h1c, 8'h3e);
		wr(8'h1c, 8'h00);
		rd(8'h1c, 8'h3e);
		wr(8'h1c, 8'hff);
		rd(8'h1c, 8'h00);
		wr(8'h13, 8'hff);
		wr(8'h14, 8'hff);
		flip(17'h0_0004);
		rd(8'h13, 8'h01);
		chk1(grp_n, 1'b1);
		wr(8'h19, 8'h01);
		repeat (3) @(negedge clk_sys);
		chk1(grp_n, 1'b0);
		wr(8'h17, 8'he0);
		repeat (3) @(negedge clk_sys);
		chk1(pin_n, 1'b0);
		chk1(ser, 1'b1);
		chk1(pme, 1'b1);
		wr(8'h13, 8'h01);
		repeat (3) @(negedge clk_sys);
		chk1(grp_n, 1'b1);
		chk1(pin_n, 1'b1);
		chk1(ser, 1'b0);
		chk1(pme, 1'b0);
		flip(17'h1_0000);
		rd(8'h14, 8'h80);
		// clear lands in the very cycle the new pin edge is seen
		fork
			flip(17'h0_0004);
			begin
				repeat (3) @(posedge clk_sys);
				wr(8'h13, 8'h01);
			end
		join
		rd(8'h13, 8'h01);
		chk1(grp_n, 1'b0);
		stop_test();
	end
endmodule : tb
